// file: rtl/jsi_pkg.sv
// constants and state types for the scan and indirect flash access block
package jsi_pkg;
  // instruction codes
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_IDCODE = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [1:0] IR_IND_TOP = 2'h2;
  // indirect register selectors, low two instruction bits
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_SCALE = 2'h3;
  // indirect word layout
  localparam int IND_W = 20;
  localparam int PAY_W = 18;
  localparam int OP_HI = 19;
  localparam int OP_LO = 18;
  // control register fields
  localparam int SCRATCH_BIT = 7;
  localparam int WM_HI = 6;
  localparam int WM_LO = 4;
  localparam int RM_HI = 3;
  localparam int RM_LO = 0;
  localparam logic [2:0] WM_STORE = 3'h0;
  localparam logic [2:0] WM_BYTE = 3'h1;
  localparam logic [2:0] WM_ERASE = 3'h2;
  localparam logic [3:0] RM_ONE = 4'h1;
  localparam logic [3:0] RM_BLOCK = 4'h2;
  localparam logic [7:0] ERASE_KEY = 8'hA5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  // port 7 boundary segment, local bit 0 is chain bit 118
  localparam int P7_W = 8;
  localparam int BSR_W = 16;
  localparam int BSR_FIRST = 118;
  localparam int ID_W = 32;
  typedef enum logic [1:0] {FC_READ = 2'h0, FC_WRITE = 2'h1, FC_ERASE = 2'h2} jsi_fcmd_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_FIN = 2'b11} jsi_st_t;
  typedef struct packed {
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_upd;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [IND_W-1:0] ind_sh;
    logic busy;
    logic cap_busy;
    logic go_tgl;
    logic op_wr;
    logic [1:0] op_sel;
    logic [PAY_W-1:0] op_pay;
    logic [P7_W-1:0] pin_s1;
    logic [P7_W-1:0] pin_s2;
    logic done_s1;
    logic done_s2;
    logic done_prev;
  } jsi_tck_t;
  typedef struct packed {
    jsi_st_t st;
    logic go_s1;
    logic go_s2;
    logic go_prev;
    logic done_tgl;
    logic [7:0] ctrl;
    logic [15:0] addr;
    logic [7:0] scale;
    logic [7:0] data;
    logic [PAY_W-1:0] result;
    logic ext_s1;
    logic ext_s2;
    logic [P7_W-1:0] pin_s1;
    logic [P7_W-1:0] pin_s2;
    logic [P7_W-1:0] core_in;
    logic req;
    jsi_fcmd_t cmd;
  } jsi_sys_t;
endpackage

// file: rtl/jsi_scan.sv
// scan path, identification and indirect flash register access
`timescale 1ns/10ps
`default_nettype none
module jsi_scan #(
  parameter logic [3:0] VERSION = 4'h1,   // arbitrary value
  parameter logic [15:0] PART = 16'h0001, // arbitrary value
  parameter logic [10:0] MAKER = 11'h001  // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tdi,
  output logic tdo,
  input wire logic [3:0] ir_code,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic [jsi_pkg::P7_W-1:0] core_p7_out,
  input wire logic [jsi_pkg::P7_W-1:0] core_p7_oe,
  output logic [jsi_pkg::P7_W-1:0] core_p7_in,
  input wire logic core_pullup_en,
  output logic pullup_en,
  input wire logic [jsi_pkg::P7_W-1:0] port7_pin_in,
  output logic [jsi_pkg::P7_W-1:0] port7_pin_out,
  output logic [jsi_pkg::P7_W-1:0] port7_pin_oe_n,
  output logic flash_req,
  output logic [1:0] flash_cmd,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_scratch,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_ack
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_ind(input logic [3:0] ir);
    is_ind = (ir[3:2] == jsi_pkg::IR_IND_TOP);
  endfunction

  function automatic logic is_bsr(input logic [3:0] ir);
    is_bsr = (ir == jsi_pkg::IR_EXTEST) || (ir == jsi_pkg::IR_SAMPLE);
  endfunction

  jsi_pkg::jsi_tck_t tq_reg;
  jsi_pkg::jsi_tck_t tq_next;
  jsi_pkg::jsi_sys_t sq_reg;
  jsi_pkg::jsi_sys_t sq_next;
  logic extest;
  logic [jsi_pkg::ID_W-1:0] id_word;
  logic [jsi_pkg::BSR_W-1:0] bsr_cap;
  logic [7:0] wr8;
  logic [2:0] wmode;
  logic [3:0] rmode;

  assign extest = (ir_code == jsi_pkg::IR_EXTEST);
  assign id_word = {VERSION, PART, MAKER, 1'b1};

  // ----------------------------------------
  // port 7 boundary segment
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < jsi_pkg::P7_W; gi++) begin : g_p7
      assign bsr_cap[2*gi] = core_p7_oe[gi];
      assign bsr_cap[2*gi+1] = tq_reg.pin_s2[gi];
      assign port7_pin_out[gi] = extest ? tq_reg.bsr_upd[2*gi+1] : core_p7_out[gi];
      assign port7_pin_oe_n[gi] = extest ? ~tq_reg.bsr_upd[2*gi] : ~core_p7_oe[gi];
    end
  endgenerate

  // pullups released while pins are under scan control
  assign pullup_en = extest ? 1'b0 : core_pullup_en;

  // ----------------------------------------
  // test clock domain
  // ----------------------------------------
  always_comb begin
    tq_next = tq_reg;
    tq_next.pin_s1 = port7_pin_in;
    tq_next.pin_s2 = tq_reg.pin_s1;
    tq_next.done_s1 = sq_reg.done_tgl;
    tq_next.done_s2 = tq_reg.done_s1;
    // completion seen from the system side
    if (tq_reg.done_s2 != tq_reg.done_prev) begin
      tq_next.done_prev = tq_reg.done_s2;
      tq_next.busy = 1'b0;
    end
    if (capture_dr) begin
      if (is_bsr(ir_code)) begin
        tq_next.bsr_sh = bsr_cap;
      end else if (ir_code == jsi_pkg::IR_IDCODE) begin
        tq_next.id_sh = id_word;
      end else if (is_ind(ir_code)) begin
        tq_next.ind_sh = {1'b0, sq_reg.result, tq_reg.busy};
        tq_next.cap_busy = tq_reg.busy;
      end else begin
        tq_next.byp = 1'b0;
      end
    end else if (shift_dr) begin
      if (is_bsr(ir_code)) begin
        tq_next.bsr_sh = {tdi, tq_reg.bsr_sh[jsi_pkg::BSR_W-1:1]};
      end else if (ir_code == jsi_pkg::IR_IDCODE) begin
        tq_next.id_sh = {tdi, tq_reg.id_sh[jsi_pkg::ID_W-1:1]};
      end else if (is_ind(ir_code)) begin
        // short shifts land at the top
        tq_next.ind_sh = {tdi, tq_reg.ind_sh[jsi_pkg::IND_W-1:1]};
      end else begin
        tq_next.byp = tdi;
      end
    end else if (update_dr) begin
      if (is_bsr(ir_code)) begin
        tq_next.bsr_upd = tq_reg.bsr_sh;
      end else if (is_ind(ir_code)) begin
        // a leading zero is a poll and updates nothing
        // start only if busy was captured low
        if (tq_reg.ind_sh[jsi_pkg::OP_HI] && !tq_reg.cap_busy && !tq_reg.busy) begin
          tq_next.go_tgl = ~tq_reg.go_tgl;
          tq_next.busy = 1'b1;
          tq_next.op_wr = tq_reg.ind_sh[jsi_pkg::OP_LO];
          tq_next.op_sel = ir_code[1:0];
          tq_next.op_pay = tq_reg.ind_sh[jsi_pkg::PAY_W-1:0];
        end
      end
    end
  end

  // test clock register
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      tq_reg <= '0;
    end else begin
      tq_reg <= tq_next;
    end
  end

  // serial output, a mux of shift stages only
  always_comb begin
    if (is_bsr(ir_code)) begin
      tdo = tq_reg.bsr_sh[0];
    end else if (ir_code == jsi_pkg::IR_IDCODE) begin
      tdo = tq_reg.id_sh[0];
    end else if (is_ind(ir_code)) begin
      tdo = tq_reg.ind_sh[0];
    end else begin
      tdo = tq_reg.byp;
    end
  end

  // ----------------------------------------
  // system clock domain
  // ----------------------------------------
  // op fields are stable while busy, so they are read after the toggle settles
  assign wr8 = tq_reg.op_pay[jsi_pkg::PAY_W-1 -: 8];
  assign wmode = sq_reg.ctrl[jsi_pkg::WM_HI:jsi_pkg::WM_LO];
  assign rmode = sq_reg.ctrl[jsi_pkg::RM_HI:jsi_pkg::RM_LO];

  always_comb begin
    sq_next = sq_reg;
    sq_next.go_s1 = tq_reg.go_tgl;
    sq_next.go_s2 = sq_reg.go_s1;
    sq_next.ext_s1 = extest;
    sq_next.ext_s2 = sq_reg.ext_s1;
    sq_next.pin_s1 = port7_pin_in;
    sq_next.pin_s2 = sq_reg.pin_s1;
    // core sees all ones under extest
    sq_next.core_in = sq_reg.ext_s2 ? '1 : sq_reg.pin_s2;
    unique case (sq_reg.st)
      jsi_pkg::ST_IDLE: begin
        if (sq_reg.go_s2 != sq_reg.go_prev) begin
          sq_next.go_prev = sq_reg.go_s2;
          sq_next.st = jsi_pkg::ST_FIN;
          if (tq_reg.op_wr) begin
            unique case (tq_reg.op_sel)
              jsi_pkg::SEL_CTRL: sq_next.ctrl = wr8;
              jsi_pkg::SEL_SCALE: sq_next.scale = wr8;
              jsi_pkg::SEL_ADDR: sq_next.addr = tq_reg.op_pay[jsi_pkg::PAY_W-1 -: 16];
              jsi_pkg::SEL_DATA: begin
                sq_next.data = wr8;
                // write mode decides the flash action
                if (wmode == jsi_pkg::WM_BYTE) begin
                  sq_next.req = 1'b1;
                  sq_next.cmd = jsi_pkg::FC_WRITE;
                  sq_next.st = jsi_pkg::ST_WAIT;
                end else if (wmode == jsi_pkg::WM_ERASE && wr8 == jsi_pkg::ERASE_KEY) begin
                  sq_next.req = 1'b1;
                  sq_next.cmd = jsi_pkg::FC_ERASE;
                  sq_next.st = jsi_pkg::ST_WAIT;
                end
              end
            endcase
          end else begin
            // short registers sit in the low bits
            unique case (tq_reg.op_sel)
              jsi_pkg::SEL_CTRL: sq_next.result = {10'h000, sq_reg.ctrl};
              jsi_pkg::SEL_SCALE: sq_next.result = {10'h000, sq_reg.scale};
              jsi_pkg::SEL_ADDR: sq_next.result = {2'h0, sq_reg.addr};
              jsi_pkg::SEL_DATA: begin
                // read mode decides whether flash is read
                if (rmode == jsi_pkg::RM_ONE || rmode == jsi_pkg::RM_BLOCK) begin
                  sq_next.req = 1'b1;
                  sq_next.cmd = jsi_pkg::FC_READ;
                  sq_next.st = jsi_pkg::ST_WAIT;
                end else begin
                  sq_next.result = {10'h000, sq_reg.data};
                end
              end
            endcase
          end
        end
      end
      jsi_pkg::ST_WAIT: begin
        if (flash_ack) begin
          sq_next.req = 1'b0;
          sq_next.st = jsi_pkg::ST_FIN;
          if (sq_reg.cmd == jsi_pkg::FC_READ) begin
            sq_next.data = flash_rdata;
            sq_next.result = {10'h000, flash_rdata};
          end
          if (sq_reg.cmd != jsi_pkg::FC_ERASE) begin
            sq_next.addr = sq_reg.addr + jsi_pkg::ADDR_ONE;
          end
        end
      end
      jsi_pkg::ST_FIN: begin
        // hand completion back to the test clock side
        sq_next.done_tgl = ~sq_reg.done_tgl;
        sq_next.st = jsi_pkg::ST_IDLE;
      end
      default: sq_next.st = jsi_pkg::ST_IDLE;
    endcase
  end

  // system clock register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sq_reg <= '0;
      sq_reg.ctrl <= jsi_pkg::CTRL_RST;
      sq_reg.addr <= jsi_pkg::ADDR_RST;
    end else begin
      sq_reg <= sq_next;
    end
  end

  assign core_p7_in = sq_reg.core_in;
  assign flash_req = sq_reg.req;
  assign flash_cmd = sq_reg.cmd;
  assign flash_addr = sq_reg.addr;
  assign flash_wdata = sq_reg.data;
  assign flash_scratch = sq_reg.ctrl[jsi_pkg::SCRATCH_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_start;
    update_dr && is_ind(ir_code) && tq_reg.ind_sh[jsi_pkg::OP_HI] && !tq_reg.cap_busy
      && !tq_reg.busy;
  endsequence
  sequence s_held;
    update_dr && is_ind(ir_code) && (!tq_reg.ind_sh[jsi_pkg::OP_HI] || tq_reg.cap_busy);
  endsequence

  property p_busy_set;
    @(posedge tck) disable iff (!resetn) s_start |=> tq_reg.busy && tq_reg.go_tgl != $past(tq_reg.go_tgl);
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set at start");

  property p_held;
    @(posedge tck) disable iff (!resetn) s_held |=> $stable(tq_reg.go_tgl) && $stable(tq_reg.op_pay);
  endproperty
  a_held: assert property (p_held) else $error("poll or busy word started work");

  property p_cap_word;
    @(posedge tck) disable iff (!resetn)
      capture_dr && is_ind(ir_code)
      |=> !tq_reg.ind_sh[jsi_pkg::OP_HI] && tq_reg.ind_sh[0] == $past(tq_reg.busy);
  endproperty
  a_cap_word: assert property (p_cap_word) else $error("indirect capture format");

  property p_idcode;
    @(posedge tck) disable iff (!resetn)
      capture_dr && ir_code == jsi_pkg::IR_IDCODE |=> tq_reg.id_sh[0] && tq_reg.id_sh[11:1] == MAKER;
  endproperty
  a_idcode: assert property (p_idcode) else $error("identity capture wrong");

  property p_sample_pins;
    @(posedge tck) disable iff (!resetn) ir_code == jsi_pkg::IR_SAMPLE |-> port7_pin_out == core_p7_out;
  endproperty
  a_sample_pins: assert property (p_sample_pins) else $error("sample drove the pins");

  property p_bypass;
    @(posedge tck) disable iff (!resetn)
      shift_dr && ir_code == jsi_pkg::IR_BYPASS |=> tq_reg.byp == $past(tdi);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass stage wrong");

  property p_force_high;
    @(posedge clk_sys) disable iff (!resetn) sq_reg.ext_s2 |=> core_p7_in == '1;
  endproperty
  a_force_high: assert property (p_force_high) else $error("core inputs not forced");

  property p_addr_step;
    @(posedge clk_sys) disable iff (!resetn)
      sq_reg.st == jsi_pkg::ST_WAIT && flash_ack && sq_reg.cmd != jsi_pkg::FC_ERASE
      |=> flash_addr == $past(flash_addr) + jsi_pkg::ADDR_ONE ##1 $stable(flash_addr);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not advanced");

  property p_erase_key;
    @(posedge clk_sys) disable iff (!resetn)
      flash_req && flash_cmd == jsi_pkg::FC_ERASE |-> flash_wdata == jsi_pkg::ERASE_KEY;
  endproperty
  a_erase_key: assert property (p_erase_key) else $error("erase without key");

  property p_finish;
    @(posedge clk_sys) disable iff (!resetn)
      sq_reg.st == jsi_pkg::ST_FIN |=> sq_reg.st == jsi_pkg::ST_IDLE && $changed(sq_reg.done_tgl);
  endproperty
  a_finish: assert property (p_finish) else $error("completion not signalled");
endmodule // jsi_scan
`default_nettype wire

// file: sim/jsi_flash_model.sv
// behavioural flash array answering the block's flash port
`timescale 1ns/10ps
`default_nettype none
module jsi_flash_model #(
  parameter int DELAY = 40,
  parameter logic [7:0] RD_VAL = 8'hC3
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic flash_req,
  input wire logic [1:0] flash_cmd,
  output logic [7:0] flash_rdata,
  output logic flash_ack,
  output logic [7:0] n_wr,
  output logic [7:0] n_rd,
  output logic [7:0] n_er
);
  int cnt;
  logic served;
  // slow answer keeps busy visible; data toggles while not valid
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      served <= 1'b0;
      flash_ack <= 1'b0;
      flash_rdata <= 8'h00;
      n_wr <= 8'h00;
      n_rd <= 8'h00;
      n_er <= 8'h00;
    end else begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req && !served) begin
        cnt <= cnt + 1;
        if (cnt == DELAY) begin
          cnt <= 0;
          served <= 1'b1;
          flash_ack <= 1'b1;
          flash_rdata <= RD_VAL;
          n_rd <= n_rd + 8'(flash_cmd == 2'h0);
          n_wr <= n_wr + 8'(flash_cmd == 2'h1);
          n_er <= n_er + 8'(flash_cmd == 2'h2);
        end
      end else if (!flash_req) begin
        served <= 1'b0;
      end
    end
  end
endmodule // jsi_flash_model
`default_nettype wire

// file: sim/jsi_scan_tb.sv
// self-checking bench for the scan and indirect flash access block
`timescale 1ns/10ps
`default_nettype none
module jsi_scan_tb;
  logic clk_sys, resetn, tck, tdi, tdo, capture_dr, shift_dr, update_dr, pullup_en;
  logic core_pullup_en, flash_req, flash_scratch, flash_ack;
  logic [3:0] ir_code;
  logic [7:0] core_p7_out, core_p7_oe, core_p7_in, port7_pin_in, port7_pin_out;
  logic [7:0] port7_pin_oe_n, flash_wdata, flash_rdata, n_wr, n_rd, n_er;
  logic [1:0] flash_cmd;
  logic [15:0] flash_addr, a0;
  logic [31:0] got;
  int mismatches, total_checks, cycles;
  localparam logic [7:0] CTRL = {1'b1, jsi_pkg::WM_BYTE, jsi_pkg::RM_ONE};

  jsi_scan i_dut (.clk_sys(clk_sys), .resetn(resetn), .tck(tck), .tdi(tdi), .tdo(tdo),
    .ir_code(ir_code), .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr),
    .core_p7_out(core_p7_out), .core_p7_oe(core_p7_oe), .core_p7_in(core_p7_in),
    .core_pullup_en(core_pullup_en), .pullup_en(pullup_en), .port7_pin_in(port7_pin_in),
    .port7_pin_out(port7_pin_out), .port7_pin_oe_n(port7_pin_oe_n), .flash_req(flash_req),
    .flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_scratch(flash_scratch), .flash_rdata(flash_rdata), .flash_ack(flash_ack));
  jsi_flash_model i_flash (.clk_sys(clk_sys), .resetn(resetn), .flash_req(flash_req),
    .flash_cmd(flash_cmd), .flash_rdata(flash_rdata), .flash_ack(flash_ack),
    .n_wr(n_wr), .n_rd(n_rd), .n_er(n_er));

  // ----------------------------------------
  // clocks and run limit
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one link clock period; the link clock rests low outside frames
  task automatic pulse();
    #24 tck = 1'b1;
    #24 tck = 1'b0;
  endtask
  // idle edges let pin synchronisers settle, then capture, shift, update
  task automatic scan(input logic [3:0] ir, input int n, input logic [31:0] din);
    ir_code = ir;
    got = '0;
    repeat (3) pulse();
    capture_dr = 1'b1;
    pulse();
    capture_dr = 1'b0;
    shift_dr = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi = din[i];
      got[i] = tdo;
      pulse();
    end
    shift_dr = 1'b0;
    update_dr = 1'b1;
    pulse();
    update_dr = 1'b0;
  endtask
  // short shifts send only the top n bits of the operation word
  task automatic ind(input logic [3:0] ir, input int n, input logic [19:0] w);
    scan(ir, n, 32'(w >> (20 - n)));
  endtask
  // repeat a word until its capture shows idle; single-bit words only poll
  task automatic until_idle(input logic [3:0] ir, input int n, input logic [19:0] w);
    for (int k = 0; k < 60; k++) begin
      ind(ir, n, w);
      if (got[0] === 1'b0) return;
    end
    chk(32'h1, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [15:0] ilv(input logic [7:0] e, input logic [7:0] d);
    for (int k = 0; k < 8; k++) ilv[2*k +: 2] = {d[k], e[k]};
  endfunction

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {tck, tdi, capture_dr, shift_dr, update_dr, resetn} = '0;
    ir_code = jsi_pkg::IR_BYPASS;
    {core_p7_out, core_p7_oe, port7_pin_in} = {8'h55, 8'hF0, 8'h3C};
    core_pullup_en = 1'b1;
    #7 repeat (3) pulse();
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    scan(jsi_pkg::IR_IDCODE, 32, 32'h0);
    chk(got, 32'h1000_1003);
    // a one shifted in first shows on the second shift, behind the captured zero
    scan(jsi_pkg::IR_BYPASS, 2, 32'h1);
    chk(got[1:0], 2'b10);
    // host selects the register first and keeps it while busy
    // host order
    ind(4'h8, 10, {2'b11, CTRL, 10'h0});
    until_idle(4'h8, 1, 20'h0);
    chk(flash_scratch, 1'b1);
    ind(4'h8, 2, 20'h80000);
    until_idle(4'h8, 1, 20'h0);
    ind(4'h8, 9, 20'h0);
    chk(got[8:0], {CTRL, 1'b0});
    ind(4'hA, 20, {2'b11, 16'h0010, 2'b00});
    until_idle(4'hA, 1, 20'h0);
    ind(4'hA, 2, 20'h80000);
    until_idle(4'hA, 1, 20'h0);
    ind(4'hA, 20, 20'h0);
    chk(got[19:0], 20'h00020);
    ind(4'h9, 10, {2'b11, 8'h5A, 10'h0});
    ind(4'h9, 1, 20'h0);
    chk(got[0], 1'b1);
    ind(4'h9, 10, {2'b11, 8'h33, 10'h0});
    until_idle(4'h9, 10, {2'b11, 8'h77, 10'h0});
    until_idle(4'h9, 1, 20'h0);
    chk({n_wr, flash_wdata}, 16'h0277);
    chk(flash_addr, 16'h0012);
    ind(4'h9, 2, 20'h80000);
    until_idle(4'h9, 1, 20'h0);
    ind(4'h9, 9, 20'h0);
    chk({n_rd, 7'h0, got[8:0]}, {8'h01, 7'h0, 8'hC3, 1'b0});
    chk(flash_addr, 16'h0013);
    ind(4'h8, 10, {2'b11, 1'b0, jsi_pkg::WM_ERASE, 4'h0, 10'h0});
    until_idle(4'h8, 1, 20'h0);
    ind(4'h9, 10, {2'b11, 8'h00, 10'h0});
    until_idle(4'h9, 1, 20'h0);
    chk(n_er, 8'h00);
    a0 = flash_addr;
    ind(4'h9, 10, {2'b11, 8'hA5, 10'h0});
    until_idle(4'h9, 1, 20'h0);
    chk({n_er, flash_addr}, {8'h01, a0});
    // read mode 0 returns the data register without a flash read
    ind(4'h9, 2, 20'h80000);
    until_idle(4'h9, 1, 20'h0);
    ind(4'h9, 9, 20'h0);
    chk({n_rd, 7'h0, got[8:0]}, {8'h01, 7'h0, 8'hA5, 1'b0});
    ind(4'h8, 10, {2'b11, 1'b0, jsi_pkg::WM_STORE, jsi_pkg::RM_BLOCK, 10'h0});
    until_idle(4'h8, 1, 20'h0);
    ind(4'h9, 2, 20'h80000);
    until_idle(4'h9, 1, 20'h0);
    chk({n_rd, n_wr, flash_addr}, {8'h02, 8'h02, a0 + 16'h0001});
    // scale register holds a byte and reads back right aligned
    ind(4'hB, 10, {2'b11, 8'h3C, 10'h0});
    until_idle(4'hB, 1, 20'h0);
    ind(4'hB, 2, 20'h80000);
    until_idle(4'hB, 1, 20'h0);
    ind(4'hB, 9, 20'h0);
    chk(got[8:0], {8'h3C, 1'b0});
    // boundary segment, sample then external test
    scan(jsi_pkg::IR_SAMPLE, 16, 32'(ilv(8'h33, 8'hC5)));
    chk(got[15:0], ilv(8'hF0, 8'h3C));
    chk({port7_pin_out, port7_pin_oe_n}, 16'h550F);
    repeat (4) @(negedge clk_sys);
    chk({core_p7_in, pullup_en}, {8'h3C, 1'b1});
    ir_code = jsi_pkg::IR_EXTEST;
    // new pin levels so capture and core forcing are told apart
    port7_pin_in = 8'hA6;
    #1 chk({port7_pin_out, port7_pin_oe_n}, 16'hC5CC);
    scan(jsi_pkg::IR_EXTEST, 16, 32'(ilv(8'h0F, 8'h96)));
    chk(got[15:0], ilv(8'hF0, 8'hA6));
    chk({port7_pin_out, port7_pin_oe_n}, 16'h96F0);
    repeat (5) @(negedge clk_sys);
    chk({core_p7_in, pullup_en}, {8'hFF, 1'b0});
    tally_and_finish();
  end
endmodule // jsi_scan_tb
`default_nettype wire
